// ==== sim/rca_testbench.sv ====
// testbench: bus-level checks of registers, calendar, alarm and pin select.
// assumes rca_top with a short reference divider; the bench makes the
// reference edges and the rc oscillator level itself.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [4:0] PAD = rca_pkg::ADR_PAD_CONFIG;
  localparam logic [4:0] ALM = rca_pkg::ADR_ALARM_CONFIG;
  localparam logic [4:0] WIN = rca_pkg::ADR_ALARM_WINDOW;
  localparam logic [4:0] MAIN = rca_pkg::ADR_MAIN_CONFIG;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [4:0] adr = 5'h00;
  logic [31:0] wdat = 32'h00000000;
  logic [3:0] sel = 4'h0;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic [31:0] rdat;
  logic ack;
  logic secondary_crystal_oscillator = 1'b0;
  logic lowpower_rc_oscillator = 1'b0;
  logic ref_sel = 1'b1;
  logic pin;
  logic evt;
  logic ref_run = 1'b0;
  logic [2:0] ref_cnt = 3'h0;
  logic [15:0] q;
  int n_errors = 0;
  int tests_run = 0;
  int n_evt = 0;
  int n_pin = 0;
  logic [15:0] rs [4] = '{16'h0000, 16'h0101, 16'h0000, 16'h0000};
  logic [15:0] wv [4] = '{16'hFF99, 16'hF231, 16'hF623, 16'hD9D9};
  logic [15:0] mv [4] = '{16'h0099, 16'h1231, 16'h0623, 16'h5959};

  always #5 clk_i = ~clk_i;

  rca_top #(.REF_DIV(2)) dut
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_adr_i(adr),
    .wb_dat_i(wdat),
    .wb_sel_i(sel),
    .wb_we_i(we),
    .wb_cyc_i(cyc),
    .wb_stb_i(stb),
    .wb_dat_o(rdat),
    .wb_ack_o(ack),
    .secondary_crystal_oscillator_i(secondary_crystal_oscillator),
    .lowpower_rc_oscillator_i(lowpower_rc_oscillator),
    .reference_clock_select_i(ref_sel),
    .calendar_output_pin_o(pin),
    .alarm_event_o(evt)
  );

  // reference toggles every 8 clocks while running: one rise per 16 clocks
  always @(posedge clk_i)
  begin
    if (ref_run)
    begin
      ref_cnt <= ref_cnt + 3'h1;
      if (ref_cnt == 3'h7)
        secondary_crystal_oscillator <= ~secondary_crystal_oscillator;
    end
    else
      ref_cnt <= 3'h0;
  end

  always @(posedge clk_i)
  begin
    if (evt === 1'b1)
      n_evt++;
    if (pin === 1'b1)
      n_pin++;
  end

  task automatic give_verdict();
    if (n_errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one classic cycle; released at the edge that samples ack, or after 20 clocks without it
  task automatic bus(input logic [4:0] a, input logic w,
                     input logic [15:0] d);
    int n;
    @(posedge clk_i);
    adr <= a;
    we <= w;
    wdat <= {16'h0000, d};
    sel <= 4'h3;
    cyc <= 1'b1;
    stb <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    q = rdat[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1)
    begin
      n_errors++;
      $display("mismatch at %0t: no bus answer", $time);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    bus(a, 1'b1, d);
  endtask

  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    bus(a, 1'b0, 16'h0000);
    chk(q, exp);
  endtask

  task automatic run_ref(input int n);
    ref_run <= 1'b1;
    repeat (n) @(posedge clk_i);
    ref_run <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask

  // february 28 23:59:59 of year yr, then exactly two seconds run
  task automatic leap_run(input logic [15:0] yr, input logic [15:0] md,
                          input logic [15:0] evts);
    wr(rca_pkg::ADR_YEAR, yr);
    wr(rca_pkg::ADR_MONTH_DAY, 16'h0228);
    wr(rca_pkg::ADR_WEEKDAY_HOUR, 16'h0023);
    wr(rca_pkg::ADR_MINUTE_SECOND, 16'h5959);
    wr(ALM, 16'hA400);
    n_evt = 0;
    run_ref(128);
    rd(rca_pkg::ADR_MONTH_DAY, md);
    chk(16'(n_evt), evts);
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    give_verdict();
  end

  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(PAD, 16'h0000);
    rd(ALM, 16'h0000);
    rd(MAIN, 16'h0000);
    for (int k = 0; k < 4; k++)
      wr(5'(8 + 4 * k), 16'h0111);
    for (int k = 0; k < 4; k++)
      rd(5'(8 + 4 * k), rs[k]);
    wr(MAIN, 16'h2000);
    for (int k = 0; k < 4; k++)
      wr(5'(8 + 4 * k), wv[k]);
    for (int k = 0; k < 4; k++)
      rd(5'(8 + 4 * k), mv[k]);
    // four reference rises are one second: 99-12-31 day 6 23:59:59 wraps
    run_ref(68);
    for (int k = 0; k < 4; k++)
      rd(5'(8 + 4 * k), rs[k]);
    wr(ALM, 16'h0200);
    wr(WIN, 16'h1229);
    wr(WIN, 16'h0312);
    wr(WIN, 16'h5930);
    rd(ALM, 16'h0000);
    wr(ALM, 16'h0200);
    rd(WIN, 16'h1229);
    rd(WIN, 16'h0312);
    rd(WIN, 16'h5930);
    rd(WIN, 16'h5930);
    wr(PAD, 16'hFFFF);
    rd(PAD, 16'h0007);
    wr(PAD, 16'h0000);
    wr(MAIN, 16'h2400);
    wr(ALM, 16'h8002);
    n_evt = 0;
    n_pin = 0;
    run_ref(208);
    rd(ALM, 16'h0000);
    chk(16'(n_evt), 16'h0003);
    chk(16'(n_pin), 16'h0003);
    wr(ALM, 16'hC000);
    ref_run <= 1'b1;
    for (int n = 0; n < 200 && evt !== 1'b1; n++)
      @(posedge clk_i);
    rd(ALM, 16'hC0FF);
    ref_run <= 1'b0;
    wr(ALM, 16'h0000);
    wr(MAIN, 16'h2000);
    wr(PAD, 16'h0004);
    n_pin = 0;
    run_ref(64);
    chk(16'(n_pin), 16'h0000);
    wr(MAIN, 16'h2400);
    run_ref(64);
    chk(16'(n_pin > 16), 16'h0001);
    ref_sel <= 1'b0;
    // let the old reference level drain out of the pin pipeline
    repeat (4) @(posedge clk_i);
    n_pin = 0;
    run_ref(64);
    chk(16'(n_pin), 16'h0000);
    lowpower_rc_oscillator <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk(16'(n_pin > 4), 16'h0001);
    lowpower_rc_oscillator <= 1'b0;
    ref_sel <= 1'b1;
    wr(PAD, 16'h0002);
    n_pin = 0;
    run_ref(160);
    chk(16'(n_pin > 32 && n_pin < 128), 16'h0001);
    // ten-second alarm: fires on the tick where seconds ones read 0
    wr(rca_pkg::ADR_MINUTE_SECOND, 16'h0005);
    wr(ALM, 16'h8800);
    ref_run <= 1'b1;
    for (int n = 0; n < 600 && evt !== 1'b1; n++)
      @(posedge clk_i);
    rd(rca_pkg::ADR_MINUTE_SECOND, 16'h0011);
    rd(ALM, 16'h0800);
    ref_run <= 1'b0;
    // yearly alarm on february 29: only a leap year reaches that date
    wr(ALM, 16'h0200);
    wr(WIN, 16'h0229);
    wr(WIN, 16'h0000);
    wr(WIN, 16'h0000);
    leap_run(16'h0003, 16'h0301, 16'h0000);
    leap_run(16'h0004, 16'h0229, 16'h0001);
    give_verdict();
  end
endmodule
`default_nettype wire

// ==== verilog/rca_alarm_mem.sv ====
// rca_alarm_mem: three 16-bit alarm value words, registered read.
// assumes one clock; the words have no reset and start unknown.
`timescale 1ns/1ps
`default_nettype none
module rca_alarm_mem
(
  input wire logic clk_i,
  input wire logic [1:0] waddr_i,
  input wire logic we_i,
  input wire logic [15:0] wdata_i,
  input wire logic [1:0] raddr_i,
  output logic [15:0] rdata_o,
  output logic [47:0] all_o
);
  logic [15:0] mem_q [0:2];

  always_ff @(posedge clk_i)
  begin
    if (we_i && waddr_i != 2'h3)
    begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  // unimplemented slot reads as zero
  always_ff @(posedge clk_i)
  begin
    rdata_o <= (raddr_i == 2'h3) ? 16'h0000 : mem_q[raddr_i];
  end

  assign all_o = {mem_q[2], mem_q[1], mem_q[0]};
endmodule
`default_nettype wire

// ==== verilog/rca_pkg.sv ====
// rca_pkg: register map, field layout and timing constants for the
// calendar/alarm block; shared by the main module and the testbench.
package rca_pkg;
  // word offsets on the wishbone bus (byte addresses)
  localparam logic [4:0] ADR_PAD_CONFIG = 5'h00;
  localparam logic [4:0] ADR_ALARM_CONFIG = 5'h04;
  localparam logic [4:0] ADR_YEAR = 5'h08;
  localparam logic [4:0] ADR_MONTH_DAY = 5'h0C;
  localparam logic [4:0] ADR_WEEKDAY_HOUR = 5'h10;
  localparam logic [4:0] ADR_MINUTE_SECOND = 5'h14;
  localparam logic [4:0] ADR_ALARM_WINDOW = 5'h18;
  localparam logic [4:0] ADR_MAIN_CONFIG = 5'h1C;
  // implemented-bit masks
  localparam logic [15:0] MSK_PAD = 16'h0007;
  localparam logic [15:0] MSK_YEAR = 16'h00FF;
  localparam logic [15:0] MSK_MONTH_DAY = 16'h1F3F;
  localparam logic [15:0] MSK_WEEKDAY_HOUR = 16'h073F;
  localparam logic [15:0] MSK_MINUTE_SECOND = 16'h7F7F;
  localparam logic [15:0] MSK_MAIN = 16'h2400;
  // field positions
  localparam int MAIN_UNLOCK_BIT = 13;
  localparam int MAIN_OE_BIT = 10;
  localparam int MAIN_HALF_BIT = 11;
  localparam int ALM_EN_BIT = 15;
  localparam int ALM_WRAP_BIT = 14;
  // output select codes
  localparam logic [1:0] SEL_ALARM = 2'h0;
  localparam logic [1:0] SEL_SECOND = 2'h1;
  localparam logic [1:0] SEL_REFCLK = 2'h2;
  // alarm pointer codes
  localparam logic [1:0] PTR_MIN_SEC = 2'h0;
  localparam logic [1:0] PTR_WD_HR = 2'h1;
  localparam logic [1:0] PTR_MON_DAY = 2'h2;
  // reset time value 00-01-01 day 0 00:00:00
  localparam logic [15:0] RST_MONTH_DAY = 16'h0101;
  // reference tick rate in Hz (a half-second tick takes REF_DIV edges, 3052 by default)
  localparam int REF_HZ = 32768;
endpackage

// ==== verilog/rca_top.sv ====
// rca_top: calendar counter, alarm and output pin select on wishbone.
// assumes a 100 MHz clock, a synchronous reset and a reference tick
// enable (secondary crystal or rc oscillator, chosen by strap).
`timescale 1ns/1ps
`default_nettype none
module rca_top
#(
  parameter int REF_DIV = 3052
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic secondary_crystal_oscillator_i,
  input wire logic lowpower_rc_oscillator_i,
  input wire logic reference_clock_select_i,
  output logic calendar_output_pin_o,
  output logic alarm_event_o
);
  typedef enum logic [1:0] {RCA_IDLE, RCA_ACK, RCA_DONE} rca_bus_t;

  function automatic logic [3:0] bcd_inc(input logic [3:0] v);
    bcd_inc = (v == 4'h9) ? 4'h0 : v + 4'h1;
  endfunction

  rca_bus_t bus_q;
  logic [2:0] pad_q;
  logic unlock_q, oe_q;
  logic en_q, wrap_q;
  logic [3:0] mask_q;
  logic [1:0] ptr_q;
  logic [7:0] rpt_q;
  logic [7:0] year_q;
  logic [15:0] md_q, wh_q, ms_q;
  logic strap_q, ref_q, ref_prev_q;
  logic [15:0] pre_q;
  logic half_q, half_tick;
  logic [15:0] rd_d;
  logic [47:0] alm_all;
  logic [15:0] alm_rd;
  logic alm_we;
  logic req, wr, rd, unlocked, sec_tick, hit, fire;
  logic [15:0] wd;

  assign req = wb_cyc_i && wb_stb_i && bus_q == RCA_IDLE;
  assign wr = req && wb_we_i;
  assign rd = req && !wb_we_i;
  assign wd = wb_dat_i[15:0];
  assign unlocked = unlock_q;

  // ack two cycles after the request so the alarm window read is ready
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bus_q <= RCA_IDLE;
      wb_ack_o <= 1'b0;
    end
    else
    begin
      case (bus_q)
        RCA_IDLE: if (req) bus_q <= RCA_ACK;
        RCA_ACK: bus_q <= RCA_DONE;
        RCA_DONE: bus_q <= RCA_IDLE;
        default: bus_q <= RCA_IDLE;
      endcase
      wb_ack_o <= (bus_q == RCA_ACK);
    end
  end

  // reference selection strap resampled on every clock after reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      strap_q <= 1'b0;
      ref_q <= 1'b0;
      ref_prev_q <= 1'b0;
    end
    else
    begin
      strap_q <= reference_clock_select_i;
      ref_q <= strap_q ? secondary_crystal_oscillator_i
                       : lowpower_rc_oscillator_i;
      ref_prev_q <= ref_q;
    end
  end

  // prescaler: rising edges of the reference make half-second ticks
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pre_q <= 16'h0000;
      half_q <= 1'b0;
    end
    else if (ref_q && !ref_prev_q)
    begin
      if (pre_q == 16'(REF_DIV - 1))
      begin
        pre_q <= 16'h0000;
        half_q <= !half_q;
      end
      else
      begin
        pre_q <= pre_q + 16'h0001;
      end
    end
  end
  assign half_tick = ref_q && !ref_prev_q && pre_q == 16'(REF_DIV - 1);
  assign sec_tick = half_tick && half_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pad_q <= 3'h0;
      unlock_q <= 1'b0;
      oe_q <= 1'b0;
    end
    else if (wr && wb_sel_i[0] && wb_adr_i == rca_pkg::ADR_PAD_CONFIG)
    begin
      pad_q <= wd[2:0];
    end
    else if (wr && wb_adr_i == rca_pkg::ADR_MAIN_CONFIG)
    begin
      unlock_q <= wd[rca_pkg::MAIN_UNLOCK_BIT];
      oe_q <= wd[rca_pkg::MAIN_OE_BIT];
    end
  end

  // calendar counting and gated writes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      year_q <= 8'h00;
      md_q <= rca_pkg::RST_MONTH_DAY;
      wh_q <= 16'h0000;
      ms_q <= 16'h0000;
    end
    else if (wr && wb_adr_i == rca_pkg::ADR_YEAR)
    begin
      if (unlocked) year_q <= wd[7:0];
    end
    else if (wr && wb_adr_i == rca_pkg::ADR_MONTH_DAY)
    begin
      if (unlocked) md_q <= wd & rca_pkg::MSK_MONTH_DAY;
    end
    else if (wr && wb_adr_i == rca_pkg::ADR_WEEKDAY_HOUR)
    begin
      if (unlocked) wh_q <= wd & rca_pkg::MSK_WEEKDAY_HOUR;
    end
    else if (wr && wb_adr_i == rca_pkg::ADR_MINUTE_SECOND)
    begin
      if (unlocked) ms_q <= wd & rca_pkg::MSK_MINUTE_SECOND;
    end
    else if (sec_tick)
    begin
      if (ms_q[3:0] != 4'h9)
        ms_q[3:0] <= bcd_inc(ms_q[3:0]);
      else if (ms_q[6:4] != 3'h5)
      begin
        ms_q[3:0] <= 4'h0;
        ms_q[6:4] <= ms_q[6:4] + 3'h1;
      end
      else
      begin
        ms_q[6:0] <= 7'h00;
        if (ms_q[11:8] != 4'h9)
          ms_q[11:8] <= bcd_inc(ms_q[11:8]);
        else if (ms_q[14:12] != 3'h5)
        begin
          ms_q[11:8] <= 4'h0;
          ms_q[14:12] <= ms_q[14:12] + 3'h1;
        end
        else
        begin
          ms_q[14:8] <= 7'h00;
          if (wh_q[5:0] == 6'h23)
          begin
            wh_q[5:0] <= 6'h00;
            wh_q[10:8] <= (wh_q[10:8] == 3'h6) ? 3'h0 : wh_q[10:8] + 3'h1;
            if (md_q[5:0] == last_day(md_q[12:8], year_q))
            begin
              md_q[5:0] <= 6'h01;
              if (md_q[12:8] == 5'h12)
              begin
                md_q[12:8] <= 5'h01;
                year_q[3:0] <= bcd_inc(year_q[3:0]);
                if (year_q[3:0] == 4'h9)
                  year_q[7:4] <= bcd_inc(year_q[7:4]);
              end
              else if (md_q[11:8] == 4'h9)
                md_q[12:8] <= 5'h10;
              else
                md_q[11:8] <= md_q[11:8] + 4'h1;
            end
            else if (md_q[3:0] == 4'h9)
            begin
              md_q[3:0] <= 4'h0;
              md_q[5:4] <= md_q[5:4] + 2'h1;
            end
            else
              md_q[3:0] <= md_q[3:0] + 4'h1;
          end
          else if (wh_q[3:0] == 4'h9)
          begin
            wh_q[3:0] <= 4'h0;
            wh_q[5:4] <= wh_q[5:4] + 2'h1;
          end
          else
            wh_q[3:0] <= wh_q[3:0] + 4'h1;
        end
      end
    end
  end

  // last day of a BCD month; leap when the BCD year is a multiple of 4
  function automatic logic [5:0] last_day(input logic [4:0] m,
                                          input logic [7:0] y);
    logic leap;
    leap = ((y[4] ? y[3:0] + 4'h2 : y[3:0]) % 4) == 0;
    case (m)
      5'h02: last_day = leap ? 6'h29 : 6'h28;
      5'h04, 5'h06, 5'h09, 5'h11: last_day = 6'h30;
      default: last_day = 6'h31;
    endcase
  endfunction

  // alarm match over the digits the mask selects
  always_comb
  begin
    hit = 1'b0;
    case (mask_q)
      4'h0: hit = 1'b1;
      4'h1: hit = 1'b1;
      4'h2: hit = ms_q[3:0] == alm_all[3:0];
      4'h3: hit = ms_q[6:0] == alm_all[6:0];
      4'h4: hit = ms_q[11:0] == {alm_all[11:8], 1'b0, alm_all[6:0]};
      4'h5: hit = ms_q[14:0] == alm_all[14:0];
      4'h6: hit = ms_q == alm_all[15:0] && wh_q[5:0] == alm_all[21:16];
      4'h7: hit = ms_q == alm_all[15:0] && wh_q == alm_all[31:16];
      4'h8: hit = ms_q == alm_all[15:0] && wh_q[5:0] == alm_all[21:16]
               && md_q[5:0] == alm_all[37:32];
      // feb 29 only exists in leap years: once every four years
      4'h9: hit = ms_q == alm_all[15:0] && wh_q[5:0] == alm_all[21:16]
               && md_q == alm_all[47:32];
      default: hit = 1'b0;
    endcase
  end
  assign fire = en_q && hit && (mask_q == 4'h0 ? half_tick : sec_tick);

  assign alm_we = wr && wb_adr_i == rca_pkg::ADR_ALARM_WINDOW;

  // alarm configuration, pointer and repeat counter
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      en_q <= 1'b0;
      wrap_q <= 1'b0;
      mask_q <= 4'h0;
      ptr_q <= 2'h0;
      rpt_q <= 8'h00;
    end
    else if (wr && wb_adr_i == rca_pkg::ADR_ALARM_CONFIG)
    begin
      en_q <= wd[rca_pkg::ALM_EN_BIT];
      wrap_q <= wd[rca_pkg::ALM_WRAP_BIT];
      mask_q <= wd[13:10];
      ptr_q <= wd[9:8];
      rpt_q <= wd[7:0];
    end
    else
    begin
      if (req && wb_adr_i == rca_pkg::ADR_ALARM_WINDOW
          && (wb_sel_i[1] || !wb_we_i) && ptr_q != rca_pkg::PTR_MIN_SEC)
        ptr_q <= ptr_q - 2'h1;
      if (fire)
      begin
        if (rpt_q != 8'h00 || wrap_q)
          rpt_q <= rpt_q - 8'h01;
        else
          en_q <= 1'b0;
      end
    end
  end

  rca_alarm_mem u_mem
  (
    .clk_i(clk_i),
    .waddr_i(ptr_q),
    .we_i(alm_we),
    .wdata_i(wd),
    .raddr_i(ptr_q),
    .rdata_o(alm_rd),
    .all_o(alm_all)
  );

  always_comb
  begin
    rd_d = 16'h0000;
    case (wb_adr_i)
      rca_pkg::ADR_PAD_CONFIG: rd_d = {13'h0000, pad_q};
      rca_pkg::ADR_ALARM_CONFIG: rd_d = {en_q, wrap_q, mask_q, ptr_q, rpt_q};
      rca_pkg::ADR_YEAR: rd_d = {8'h00, year_q};
      rca_pkg::ADR_MONTH_DAY: rd_d = md_q;
      rca_pkg::ADR_WEEKDAY_HOUR: rd_d = wh_q;
      rca_pkg::ADR_MINUTE_SECOND: rd_d = ms_q;
      rca_pkg::ADR_ALARM_WINDOW: rd_d = alm_rd;
      rca_pkg::ADR_MAIN_CONFIG: rd_d = {2'h0, unlock_q, 1'b0, half_q, oe_q,
                                       10'h000};
      default: rd_d = 16'h0000;
    endcase
  end

  // read data latched at the ack cycle; window latched before pointer moves
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (bus_q == RCA_ACK && !wb_we_i)
      wb_dat_o <= {16'h0000, rd_d};
  end

  // output pin
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      calendar_output_pin_o <= 1'b0;
      alarm_event_o <= 1'b0;
    end
    else
    begin
      alarm_event_o <= fire;
      if (!oe_q)
        calendar_output_pin_o <= 1'b0;
      else
        case (pad_q[2:1])
          rca_pkg::SEL_REFCLK: calendar_output_pin_o <= ref_q;
          rca_pkg::SEL_SECOND: calendar_output_pin_o <= half_q;
          rca_pkg::SEL_ALARM: calendar_output_pin_o <= fire;
          default: calendar_output_pin_o <= 1'b0;
        endcase
    end
  end

  chk_lock_year: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && wb_adr_i == rca_pkg::ADR_YEAR && !unlock_q && !sec_tick
    |=> year_q == $past(year_q)) else $error("locked year written");
  chk_pin_off: assert property (@(posedge clk_i) disable iff (rst_i)
    !oe_q |=> !calendar_output_pin_o) else $error("pin driven");
  chk_auto_off: assert property (@(posedge clk_i) disable iff (rst_i)
    fire && rpt_q == 8'h00 && !wrap_q && !wr |=> !en_q)
    else $error("alarm not disabled");
  chk_wrap_roll: assert property (@(posedge clk_i) disable iff (rst_i)
    fire && rpt_q == 8'h00 && wrap_q && !wr |=> rpt_q == 8'hFF)
    else $error("no rollover");
  chk_rpt_dec: assert property (@(posedge clk_i) disable iff (rst_i)
    fire && rpt_q != 8'h00 && !wr |=> rpt_q == $past(rpt_q) - 8'h01)
    else $error("counter not decremented");
  chk_ptr_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    ptr_q == 2'h0 && !(wr && wb_adr_i == rca_pkg::ADR_ALARM_CONFIG)
    |=> ptr_q == 2'h0) else $error("pointer left zero");
  chk_year_high: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o && !wb_we_i && $past(wb_adr_i, 2) == rca_pkg::ADR_YEAR
    |-> wb_dat_o[15:8] == 8'h00) else $error("year high nonzero");
  chk_sec_range: assert property (@(posedge clk_i) disable iff (rst_i)
    sec_tick && ms_q[6:0] == 7'h59 && !wr |=> ms_q[6:0] == 7'h00)
    else $error("second carry wrong");
endmodule
`default_nettype wire
